// >>> hw/maow_pkg.sv
package maow_pkg;
	// window addresses
	localparam logic [7:0] MAOW_ADDR_STATUS = 8'h00;
	localparam logic [7:0] MAOW_ADDR_P_HIGH = 8'h01;
	localparam logic [7:0] MAOW_ADDR_P_MID = 8'h02;
	localparam logic [7:0] MAOW_ADDR_P_LOW = 8'h03;
	localparam logic [7:0] MAOW_ADDR_T_HIGH = 8'h04;
	localparam logic [7:0] MAOW_ADDR_T_LOW = 8'h05;
	localparam logic [7:0] MAOW_ADDR_LAST = 8'h05;
	localparam logic [7:0] MAOW_ADDR_SAMPLE_STATUS = 8'h06;
	localparam logic [7:0] MAOW_ADDR_QUEUE_STATUS = 8'h0d;
	localparam logic [7:0] MAOW_RESET_VALUE = 8'h00;
	localparam logic [7:0] MAOW_RESERVED_VALUE = 8'h00;
	// field layouts
	localparam int MAOW_P_WIDTH = 20;
	localparam int MAOW_T_WIDTH = 12;
	localparam int MAOW_P_HIGH_LSB = 12;
	localparam int MAOW_P_MID_LSB = 4;
	localparam int MAOW_T_HIGH_LSB = 4;
	localparam int MAOW_LOW_NIBBLE_POS = 4;
	// queue mode field
	typedef enum logic [1:0] {
		MAOW_MODE_OFF = 2'b00,
		MAOW_MODE_CIRCULAR = 2'b01,
		MAOW_MODE_STOP_FULL = 2'b10
	} maow_mode_t;
endpackage

// >>> hw/maow_sample_if.sv
`timescale 1ns/100ps
`default_nettype none
// live sample bytes held by the capture stage, read by the window decode
interface maow_sample_if;
	logic [7:0] status;
	logic [7:0] p_high;
	logic [7:0] p_mid;
	logic [7:0] p_low;
	logic [7:0] t_high;
	logic [7:0] t_low;
	modport holder (output status, p_high, p_mid, p_low, t_high, t_low);
	modport reader (input status, p_high, p_mid, p_low, t_high, t_low);
endinterface
`default_nettype wire

// >>> hw/maow_sample_hold.sv
`timescale 1ns/100ps
`default_nettype none
module maow_sample_hold
	import maow_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wake_clear,
	// new sample from the converter
	input wire logic sample_load,
	input wire logic [7:0] sample_status_in,
	input wire logic [MAOW_P_WIDTH-1:0] pressure_in,
	input wire logic [MAOW_T_WIDTH-1:0] temperature_in,
	// held bytes
	maow_sample_if.holder hold
);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold.status <= MAOW_RESET_VALUE;
			hold.p_high <= MAOW_RESET_VALUE;
			hold.p_mid <= MAOW_RESET_VALUE;
			hold.p_low <= MAOW_RESET_VALUE;
			hold.t_high <= MAOW_RESET_VALUE;
			hold.t_low <= MAOW_RESET_VALUE;
		end else if (clk_en) begin
			if (wake_clear) begin
				// clear has priority so a stale pre-standby sample never shows
				hold.status <= MAOW_RESET_VALUE;
				hold.p_high <= MAOW_RESET_VALUE;
				hold.p_mid <= MAOW_RESET_VALUE;
				hold.p_low <= MAOW_RESET_VALUE;
				hold.t_high <= MAOW_RESET_VALUE;
				hold.t_low <= MAOW_RESET_VALUE;
			end else begin
				hold.status <= sample_status_in;
				if (sample_load) begin
					hold.p_high <= pressure_in[MAOW_P_HIGH_LSB +: 8];
					hold.p_mid <= pressure_in[MAOW_P_MID_LSB +: 8];
					hold.p_low <= {pressure_in[3:0], 4'h0};
					hold.t_high <= temperature_in[MAOW_T_HIGH_LSB +: 8];
					hold.t_low <= {temperature_in[3:0], 4'h0};
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/maow_window.sv
`timescale 1ns/100ps
`default_nettype none
module maow_window
	import maow_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// device state
	input wire logic active_mode,
	input wire logic [1:0] queue_mode,
	// live sample source
	input wire logic sample_load,
	input wire logic [7:0] sample_status_in,
	input wire logic [MAOW_P_WIDTH-1:0] pressure_in,
	input wire logic [MAOW_T_WIDTH-1:0] temperature_in,
	// queue side
	input wire logic [7:0] queue_status_in,
	input wire logic [7:0] queue_data_in,
	output logic queue_pop,
	// register port: address set, then reads
	input wire logic addr_load,
	input wire logic [7:0] addr_in,
	input wire logic rd_strobe,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_in_window,
	output logic [7:0] addr_ptr
);
	import maow_pkg::*;

	maow_sample_if smp();
	maow_mode_t mode;
	logic active_q;
	logic wake_clear;
	logic queue_on;
	logic [7:0] addr_q, addr_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q;
	logic pop_d;

	// 11 is not a defined mode; treat as queue on, as "above zero" reads
	always_comb begin
		unique case (queue_mode)
			2'b00: mode = MAOW_MODE_OFF;
			2'b01: mode = MAOW_MODE_CIRCULAR;
			2'b10: mode = MAOW_MODE_STOP_FULL;
			default: mode = MAOW_MODE_STOP_FULL;
		endcase
	end
	assign queue_on = (mode != MAOW_MODE_OFF);

	// standby to active edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_q <= 1'b0;
		end else if (clk_en) begin
			active_q <= active_mode;
		end
	end
	assign wake_clear = active_mode & ~active_q;

	maow_sample_hold u_hold (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wake_clear(wake_clear),
		.sample_load(sample_load),
		.sample_status_in(sample_status_in),
		.pressure_in(pressure_in),
		.temperature_in(temperature_in),
		.hold(smp)
	);

	// read decode, using the mode at the moment of the access
	always_comb begin
		rd_data_d = MAOW_RESERVED_VALUE;
		pop_d = 1'b0;
		addr_d = addr_q;
		if (addr_q <= MAOW_ADDR_LAST) begin
			addr_d = (addr_q == MAOW_ADDR_LAST) ? MAOW_ADDR_STATUS : addr_q + 8'h01;
		end else begin
			addr_d = addr_q + 8'h01;
		end
		if (queue_on) begin
			unique case (addr_q)
				MAOW_ADDR_STATUS: begin
					rd_data_d = queue_status_in;
					addr_d = MAOW_ADDR_P_HIGH;
				end
				MAOW_ADDR_P_HIGH: begin
					rd_data_d = queue_data_in;
					pop_d = 1'b1;
					addr_d = MAOW_ADDR_P_HIGH;
				end
				default: rd_data_d = MAOW_RESERVED_VALUE;
			endcase
		end else begin
			unique case (addr_q)
				MAOW_ADDR_STATUS: rd_data_d = smp.status;
				MAOW_ADDR_P_HIGH: rd_data_d = smp.p_high;
				MAOW_ADDR_P_MID: rd_data_d = smp.p_mid;
				MAOW_ADDR_P_LOW: rd_data_d = smp.p_low;
				MAOW_ADDR_T_HIGH: rd_data_d = smp.t_high;
				MAOW_ADDR_T_LOW: rd_data_d = smp.t_low;
				default: rd_data_d = MAOW_RESERVED_VALUE;
			endcase
		end
	end

	// address pointer; writes into the window only move the pointer (read-only)
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_q <= MAOW_ADDR_STATUS;
		end else if (clk_en) begin
			if (addr_load) begin
				addr_q <= addr_in;
			end else if (rd_strobe) begin
				addr_q <= addr_d;
			end
		end
	end

	// read data register; the wake clear wipes a pending byte too
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data_q <= MAOW_RESET_VALUE;
			rd_valid_q <= 1'b0;
		end else if (clk_en) begin
			rd_valid_q <= rd_strobe & ~addr_load;
			if (wake_clear) begin
				rd_data_q <= MAOW_RESET_VALUE;
			end else if (rd_strobe && !addr_load) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign rd_in_window = (addr_q <= MAOW_ADDR_LAST);
	assign addr_ptr = addr_q;
	// pop only on an accepted read of the port inside the window
	assign queue_pop = clk_en & rd_strobe & ~addr_load & pop_d & rd_in_window;
endmodule
`default_nettype wire

// >>> bench/maow_window_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module maow_window_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// requests
	input wire logic [1:0] queue_mode,
	input wire logic [7:0] queue_data_in,
	input wire logic addr_load,
	input wire logic [7:0] addr_in,
	input wire logic rd_strobe,
	// answers
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic queue_pop,
	input wire logic rd_in_window,
	input wire logic [7:0] addr_ptr
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence take;
		clk_en && rd_strobe && !addr_load;
	endsequence
	sequence take_port;
		take ##0 (addr_ptr == 8'h01 && queue_mode != 2'b00);
	endsequence
	read_answered_a: assert property (take |=> rd_valid) else $error("no answer");
	ptr_load_a: assert property (clk_en && addr_load |=> addr_ptr == $past(addr_in))
		else $error("pointer not loaded");
	ptr_wrap_a: assert property (take ##0 addr_ptr == 8'h05 |=> addr_ptr == 8'h00)
		else $error("no wrap");
	ptr_step_a: assert property (take ##0 addr_ptr < 8'h05 ##0 !(addr_ptr == 8'h01 &&
		queue_mode != 2'b00) |=> addr_ptr == $past(addr_ptr) + 8'h01) else $error("bad step");
	port_hold_a: assert property (take_port |=> addr_ptr == 8'h01) else $error("left port");
	port_data_a: assert property (take_port |=> rd_data == $past(queue_data_in))
		else $error("bad queue byte");
	reserved_zero_a: assert property (take ##0 queue_mode != 2'b00 ##0
		addr_ptr inside {[8'h02:8'h05]} |=> rd_data == 8'h00) else $error("reserved not zero");
	pop_match_a: assert property (queue_pop == (clk_en && rd_strobe && !addr_load &&
		addr_ptr == 8'h01 && queue_mode != 2'b00)) else $error("bad pop");
	window_flag_a: assert property (rd_in_window == (addr_ptr <= 8'h05))
		else $error("window flag wrong");
endmodule
bind maow_window maow_window_asserts u_chk(.clk, .sys_rst, .clk_en, .queue_mode,
	.queue_data_in, .addr_load, .addr_in, .rd_strobe, .rd_data, .rd_valid, .queue_pop,
	.rd_in_window,
	.addr_ptr);
`default_nettype wire

// >>> bench/maow_host.sv
`timescale 1ns/100ps
`default_nettype none
module maow_host (
	// clock
	input wire logic clk,
	// register port requests
	output logic addr_load,
	output logic [7:0] addr_in,
	output logic rd_strobe
);
	initial begin
		addr_load = 1'b0;
		addr_in = 8'h00;
		rd_strobe = 1'b0;
	end
	task automatic ld(input logic [7:0] a);
		addr_load = 1'b1;
		addr_in = a;
		@(negedge clk);
		addr_load = 1'b0;
		// released address goes to the inverse so a stale value is never trusted
		addr_in = ~a;
	endtask
	task automatic rd(input int n);
		rd_strobe = 1'b1;
		repeat (n) @(negedge clk);
		rd_strobe = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> bench/maow_window_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module maow_window_bench;
	import maow_pkg::*;
	logic clk, sys_rst, active_mode, sample_load, addr_load, rd_strobe, queue_pop, rd_valid;
	logic clk_en, rd_in_window;
	logic [1:0] queue_mode;
	logic [7:0] st, qs, qd, addr_in, rd_data, addr_ptr, e;
	logic [19:0] p;
	logic [11:0] t;
	logic [7:0] exp_q[$];
	int bad_count, comparisons, seed, m;
	maow_window dut(.clk, .sys_rst, .clk_en, .active_mode, .queue_mode, .sample_load,
		.sample_status_in(st), .pressure_in(p), .temperature_in(t), .queue_status_in(qs),
		.queue_data_in(qd), .queue_pop, .addr_load, .addr_in, .rd_strobe, .rd_data, .rd_valid,
		.rd_in_window, .addr_ptr);
	maow_host host(.clk, .addr_load, .addr_in, .rd_strobe);
	task automatic burst(input logic [7:0] a, input int n);
		host.ld(a);
		host.rd(n);
		@(negedge clk);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(negedge clk) if (rd_valid === 1'b1) begin
		e = exp_q.pop_front();
		`CHK(rd_data, e)
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		finish_test;
	end
	initial begin
		{sys_rst, active_mode, queue_mode, sample_load, st, qs, qd, p, t} = '0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		seed = 14;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		burst(8'h00, 6);
		$display("test reset done");
		active_mode = 1'b1;
		// let the wake clear pass first, it would swallow a load in the same cycle
		@(negedge clk);
		st = $random(seed);
		p = $random(seed);
		t = $random(seed);
		sample_load = 1'b1;
		@(negedge clk);
		sample_load = 1'b0;
		exp_q = '{st, p[19:12], p[11:4], {p[3:0], 4'h0}, t[11:4], {t[3:0], 4'h0}, st};
		burst(8'h00, 7);
		$display("test live sample done");
		// frozen clock enable: neither the load nor the reads may take effect
		clk_en = 1'b0;
		host.ld(8'h04);
		host.rd(2);
		clk_en = 1'b1;
		exp_q = '{p[19:12]};
		host.rd(1);
		@(negedge clk);
		$display("test clock enable done");
		// mode 11 included: treated as queue on
		for (m = 1; m < 4; m++) begin
			queue_mode = m[1:0];
			qs = $random(seed);
			qd = $random(seed);
			exp_q = '{qs, qd, qd, qd};
			burst(8'h00, 4);
			exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, qs};
			burst(8'h02, 5);
		end
		$display("test queue modes done");
		queue_mode = 2'b00;
		active_mode = 1'b0;
		@(negedge clk);
		active_mode = 1'b1;
		@(negedge clk);
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		burst(8'h01, 5);
		$display("test wake clear done");
		finish_test;
	end
endmodule
`default_nettype wire
